// >>> logic/sctr_timer.sv
// One-channel 16-bit timer: counter, prescaler and channel-0 registers.
`timescale 1ns/1ps
`default_nettype none
`include "sctr_map.svh"
module sctr_timer (
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic [`SCTR_ADR_W-1:0] adr_i,
  input  wire logic [31:0]            dat_i,
  output logic [31:0]                 dat_o,
  input  wire logic                   we_i,
  input  wire logic [3:0]             sel_i,
  input  wire logic                   cyc_i,
  input  wire logic                   stb_i,
  output logic                        ack_o,
  input  wire logic                   chanPin,
  input  wire logic                   rtcClockSource,
  input  wire logic                   extCrystalClock,
  input  wire logic                   clockOutSelect,
  output logic                        chanOutput,
  output logic                        chanOutputComp,
  output logic                        overflowPulse
);
  import sctr_pkg::*;

  sctr_bus_t   busState_r;
  logic [31:0] rdData_r;
  logic [15:0] ctrl_r;
  logic [15:0] flag_r;
  logic [15:0] chctl_r;
  logic [15:0] count_r;
  logic [15:0] divider_r;
  logic [15:0] divShadow_r;
  logic [15:0] pscCount_r;
  logic [15:0] wrapLimit_r;
  logic [15:0] chanValue_r;
  logic [15:0] activeCmp_r;
  logic [1:0]  inputSource_r;
  logic        writeFilter_r;
  logic        chanOut_r;
  logic        chanOutComp_r;
  logic        overflow_r;

  logic        busReq;
  logic        wrStrobe;
  logic        wrCtrl;
  logic        wrFlag;
  logic        wrEvgen;
  logic        wrChctl;
  logic        wrCount;
  logic        wrDiv;
  logic        wrWrap;
  logic        wrChval;
  logic        wrSrc;
  logic        wrCfg;
  logic [15:0] wrHalf;
  logic [31:0] rdMux;
  logic        counterEnable;
  logic        inputMode;
  logic        shadowEnable;
  logic        protLocked;
  logic        chanEnable;
  logic        mainPolarity;
  logic        compPolarity;
  logic        swUpdate;
  logic        swChanEvent;
  logic        counterTick;
  logic        wrapHit;
  logic        updateEvent;
  logic        captureEdge;
  logic        captureEvent;
  logic        compareEvent;
  logic        chanEvent;
  logic [15:0] compareValue;
  logic [15:0] chvalMerged;
  logic        chvalAccept;
  logic        outRef;
  logic [15:0] flagSet;
  logic [15:0] flagClr;
  logic [15:0] countNxt;
  logic [15:0] pscNxt;
  logic [15:0] chanValueNxt;

  // Merge the low half-word of a write into a register by byte lanes.
  function automatic logic [15:0] sctr_merge(input logic [15:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  sel);
    sctr_merge = {sel[1] ? data[15:8] : old[15:8],
                  sel[0] ? data[7:0]  : old[7:0]};
  endfunction

  // Bus slave: request seen in IDLE, answered in ACK, writes land there.
  assign busReq   = cyc_i & stb_i;
  assign ack_o    = (busState_r == SCTR_BUS_ACK) & busReq;
  assign wrStrobe = ack_o & we_i;
  assign wrCtrl   = wrStrobe & (adr_i == `SCTR_OFF_CTRL);
  assign wrFlag   = wrStrobe & (adr_i == `SCTR_OFF_FLAG);
  assign wrEvgen  = wrStrobe & (adr_i == `SCTR_OFF_EVGEN);
  assign wrChctl  = wrStrobe & (adr_i == `SCTR_OFF_CHCTL);
  assign wrCount  = wrStrobe & (adr_i == `SCTR_OFF_CNT);
  assign wrDiv    = wrStrobe & (adr_i == `SCTR_OFF_DIV);
  assign wrWrap   = wrStrobe & (adr_i == `SCTR_OFF_WRAP);
  assign wrChval  = wrStrobe & (adr_i == `SCTR_OFF_CHVAL);
  assign wrSrc    = wrStrobe & (adr_i == `SCTR_OFF_SRC);
  assign wrCfg    = wrStrobe & (adr_i == `SCTR_OFF_CFG);
  assign wrHalf   = {sel_i[1] ? dat_i[15:8] : 8'h00,
                     sel_i[0] ? dat_i[7:0]  : 8'h00};

  // Unmapped offsets read as zero and ignore writes.
  assign rdMux =
    (adr_i == `SCTR_OFF_CTRL)  ? {16'h0000, ctrl_r} :
    (adr_i == `SCTR_OFF_FLAG)  ? {16'h0000, flag_r} :
    (adr_i == `SCTR_OFF_CHCTL) ? {16'h0000, chctl_r} :
    (adr_i == `SCTR_OFF_CNT)   ? {16'h0000, count_r} :
    (adr_i == `SCTR_OFF_DIV)   ? {16'h0000, divider_r} :
    (adr_i == `SCTR_OFF_WRAP)  ? {16'h0000, wrapLimit_r} :
    (adr_i == `SCTR_OFF_CHVAL) ? {16'h0000, chanValue_r} :
    (adr_i == `SCTR_OFF_SRC)   ? {30'h00000000, inputSource_r} :
    (adr_i == `SCTR_OFF_CFG)   ?
      {30'h00000000, writeFilter_r, 1'b0} :
    32'h00000000;

  always_ff @(posedge clock) begin
    if (rst) begin
      busState_r <= SCTR_BUS_IDLE;
      rdData_r   <= 32'h00000000;
    end else begin
      case (busState_r)
        SCTR_BUS_IDLE: begin
          if (busReq) begin
            busState_r <= SCTR_BUS_ACK;
            rdData_r   <= rdMux;
          end
        end
        SCTR_BUS_ACK: begin
          busState_r <= SCTR_BUS_IDLE;
        end
        default: begin
          busState_r <= SCTR_BUS_IDLE;
        end
      endcase
    end
  end

  assign dat_o = rdData_r;

  // Control fields decoded from the registers.
  assign counterEnable = ctrl_r[`SCTR_CTRL_CEN];
  assign inputMode     = ctrl_r[`SCTR_CTRL_INMODE];
  assign shadowEnable  = ctrl_r[`SCTR_CTRL_SHADOW];
  // Levels 10 and 11 both have bit 5 set, so that bit alone locks polarity.
  assign protLocked    = ctrl_r[`SCTR_CTRL_PROTHI];
  assign chanEnable    = chctl_r[`SCTR_CH_EN];
  assign mainPolarity  = chctl_r[`SCTR_CH_MAINPOL];
  assign compPolarity  = chctl_r[`SCTR_CH_COMPPOL];
  assign swUpdate      = wrEvgen & sel_i[0] & dat_i[`SCTR_EVG_UPD];
  assign swChanEvent   = wrEvgen & sel_i[0] & dat_i[`SCTR_EVG_CH];

  // Prescaler: one tick every divider-plus-one timer clocks.
  assign counterTick = counterEnable &
                       (pscCount_r == divShadow_r);
  assign wrapHit     = counterTick & (count_r == wrapLimit_r);
  assign updateEvent = wrapHit | swUpdate;

  assign pscNxt = (swUpdate | counterTick) ? 16'h0000 :
                  counterEnable ? pscCount_r + 16'h0001 : pscCount_r;

  // A software write wins over the count in the same cycle.
  assign countNxt = swUpdate ? 16'h0000 :
                    wrCount ? sctr_merge(count_r, dat_i, sel_i) :
                    wrapHit ? 16'h0000 :
                    counterTick ? count_r + 16'h0001 : count_r;

  sctr_input_stage inputStage (
    .clock           (clock),
    .rst             (rst),
    .chanPin         (chanPin),
    .rtcClockSource  (rtcClockSource),
    .extCrystalClock (extCrystalClock),
    .clockOutSelect  (clockOutSelect),
    .sourceSel       (sctr_src_t'(inputSource_r)),
    .mainPolarity    (mainPolarity),
    .compPolarity    (compPolarity),
    .enable          (chanEnable & inputMode),
    .captureEdge     (captureEdge)
  );

  assign captureEvent = inputMode & (captureEdge | swChanEvent);
  assign compareValue = shadowEnable ? activeCmp_r :
                                       chanValue_r;
  assign compareEvent = ~inputMode &
                        ((counterTick & (count_r == compareValue)) |
                         swChanEvent);
  assign chanEvent    = captureEvent | compareEvent;

  // Value register: capture in input mode, software only in output mode.
  assign chvalMerged = sctr_merge(chanValue_r, dat_i, sel_i);
  assign chvalAccept = wrChval & ~inputMode &
                       ~(writeFilter_r &
                         (chvalMerged == chanValue_r));
  assign chanValueNxt = captureEvent ? count_r :
                        chvalAccept ? chvalMerged : chanValue_r;

  // Flags: hardware set wins over a write-zero clear.
  assign flagSet = {6'h00, captureEvent & flag_r[`SCTR_FLAG_CH],
                    7'h00, chanEvent, updateEvent};
  // A zero written to a flag bit clears it; a one leaves it alone.
  assign flagClr = wrFlag ? ~wrHalf & {{8{sel_i[1]}}, {8{sel_i[0]}}}
                          : 16'h0000;

  // The reference level is active while the count is below the compare value.
  assign outRef = count_r < compareValue;

  // Register file; bus writes land on the edge that ends the ack cycle.
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_r        <= `SCTR_RST16;
      flag_r        <= `SCTR_RST16;
      chctl_r       <= `SCTR_RST16;
      count_r       <= `SCTR_RST16;
      divider_r     <= `SCTR_RST16;
      divShadow_r   <= `SCTR_RST16;
      pscCount_r    <= `SCTR_RST16;
      wrapLimit_r   <= `SCTR_RST16;
      chanValue_r   <= `SCTR_RST16;
      activeCmp_r   <= `SCTR_RST16;
      inputSource_r <= 2'b00;
      writeFilter_r <= 1'b0;
    end else begin
      if (wrCtrl) begin
        ctrl_r <= sctr_merge(ctrl_r, dat_i, sel_i) & 16'h0037;
      end
      flag_r <= ((flag_r & ~flagClr) | flagSet) & 16'h0203;
      if (wrChctl & sel_i[0]) begin
        chctl_r[`SCTR_CH_EN] <= dat_i[`SCTR_CH_EN];
        if (!protLocked) begin
          chctl_r[`SCTR_CH_MAINPOL] <= dat_i[`SCTR_CH_MAINPOL];
          chctl_r[`SCTR_CH_COMPPOL] <= dat_i[`SCTR_CH_COMPPOL];
        end
      end
      count_r    <= countNxt;
      pscCount_r <= pscNxt;
      if (wrDiv) begin
        divider_r <= sctr_merge(divider_r, dat_i, sel_i);
      end
      // The update event reloads both shadow copies together.
      if (updateEvent) begin
        divShadow_r <= divider_r;
        activeCmp_r <= chanValue_r;
      end
      if (wrWrap) begin
        wrapLimit_r <= sctr_merge(wrapLimit_r, dat_i, sel_i);
      end
      chanValue_r <= chanValueNxt;
      if (wrSrc & sel_i[0]) begin
        inputSource_r <= dat_i[1:0];
      end
      if (wrCfg & sel_i[0]) begin
        writeFilter_r <= dat_i[`SCTR_CFG_WFILT];
      end
    end
  end

  // Channel outputs sit at their inactive levels while the channel is off.
  always_ff @(posedge clock) begin
    if (rst) begin
      chanOut_r     <= 1'b0;
      chanOutComp_r <= 1'b0;
      overflow_r    <= 1'b0;
    end else begin
      if (chanEnable & ~inputMode) begin
        chanOut_r     <= outRef ^ mainPolarity;
        chanOutComp_r <= ~outRef ^ compPolarity;
      end else begin
        chanOut_r     <= mainPolarity;
        chanOutComp_r <= compPolarity;
      end
      overflow_r <= wrapHit;
    end
  end

  assign chanOutput     = chanOut_r;
  assign chanOutputComp = chanOutComp_r;
  assign overflowPulse  = overflow_r;
endmodule
`default_nettype wire

// >>> logic/sctr_map.svh
// Register offsets, field positions and reset values of the channel timer.
`ifndef SCTR_MAP_SVH
`define SCTR_MAP_SVH
`define SCTR_ADR_W       8
`define SCTR_OFF_CTRL    8'h00
`define SCTR_OFF_FLAG    8'h10
`define SCTR_OFF_EVGEN   8'h14
`define SCTR_OFF_CHCTL   8'h20
`define SCTR_OFF_CNT     8'h24
`define SCTR_OFF_DIV     8'h28
`define SCTR_OFF_WRAP    8'h2c
`define SCTR_OFF_CHVAL   8'h34
`define SCTR_OFF_SRC     8'h50
`define SCTR_OFF_CFG     8'hfc
`define SCTR_CTRL_CEN    0
`define SCTR_CTRL_INMODE 1
`define SCTR_CTRL_SHADOW 2
`define SCTR_CTRL_PROTLO 4
`define SCTR_CTRL_PROTHI 5
`define SCTR_FLAG_UPD    0
`define SCTR_FLAG_CH     1
`define SCTR_FLAG_OVC    9
`define SCTR_EVG_UPD     0
`define SCTR_EVG_CH      1
`define SCTR_CH_EN       0
`define SCTR_CH_MAINPOL  1
`define SCTR_CH_COMPPOL  3
`define SCTR_CFG_WFILT   1
`define SCTR_RST16       16'h0000
`define SCTR_XTAL_HALF   4'hf
`endif

// >>> logic/sctr_pkg.sv
// Types shared by the channel timer modules.
package sctr_pkg;
  typedef enum logic [1:0] {
    SCTR_BUS_IDLE = 2'b01,
    SCTR_BUS_ACK  = 2'b10
  } sctr_bus_t;
  typedef enum logic [1:0] {
    SCTR_SRC_PIN  = 2'b00,
    SCTR_SRC_RTC  = 2'b01,
    SCTR_SRC_XTAL = 2'b10,
    SCTR_SRC_CKO  = 2'b11
  } sctr_src_t;
endpackage

// >>> logic/sctr_input_stage.sv
// Input source remap, synchronisers and polarity-selected edge detector.
`timescale 1ns/1ps
`default_nettype none
`include "sctr_map.svh"
module sctr_input_stage (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              chanPin,
  input  wire logic              rtcClockSource,
  input  wire logic              extCrystalClock,
  input  wire logic              clockOutSelect,
  input  wire sctr_pkg::sctr_src_t sourceSel,
  input  wire logic              mainPolarity,
  input  wire logic              compPolarity,
  input  wire logic              enable,
  output logic                   captureEdge
);
  import sctr_pkg::*;
  logic [3:0] syncA_r;
  logic [3:0] syncB_r;
  logic       xtalPrev_r;
  logic [3:0] xtalCnt_r;
  logic       xtalDiv_r;
  logic       selPrev_r;
  logic       selNow;
  logic       xtalRise;
  logic       rise;
  logic       fall;
  logic       active;
  logic [1:0] polPair;

  // First stage feeds only the second stage.
  always_ff @(posedge clock) begin
    if (rst) begin
      syncA_r <= 4'h0;
      syncB_r <= 4'h0;
    end else begin
      syncA_r <= {clockOutSelect, extCrystalClock, rtcClockSource, chanPin};
      syncB_r <= syncA_r;
    end
  end

  assign xtalRise = syncB_r[2] & ~xtalPrev_r;

  // Crystal clock divided by 32: toggle every 16 rising edges.
  always_ff @(posedge clock) begin
    if (rst) begin
      xtalPrev_r <= 1'b0;
      xtalCnt_r  <= 4'h0;
      xtalDiv_r  <= 1'b0;
    end else begin
      xtalPrev_r <= syncB_r[2];
      if (xtalRise) begin
        xtalCnt_r <= xtalCnt_r + 4'h1;
        if (xtalCnt_r == `SCTR_XTAL_HALF) begin
          xtalDiv_r <= ~xtalDiv_r;
        end
      end
    end
  end

  assign selNow = (sourceSel == SCTR_SRC_PIN) ? syncB_r[0] :
                  (sourceSel == SCTR_SRC_RTC) ? syncB_r[1] :
                  (sourceSel == SCTR_SRC_XTAL) ? xtalDiv_r : syncB_r[3];

  always_ff @(posedge clock) begin
    if (rst) begin
      selPrev_r <= 1'b0;
    end else begin
      selPrev_r <= selNow;
    end
  end

  assign rise = selNow & ~selPrev_r;
  assign fall = ~selNow & selPrev_r;
  assign polPair = {compPolarity, mainPolarity};
  // The reserved polarity pair gives no capture edge at all.
  assign active = (polPair == 2'b00) ? rise :
                  (polPair == 2'b01) ? fall :
                  (polPair == 2'b11) ? (rise | fall) :
                  1'b0;
  assign captureEdge = enable & active;
endmodule
`default_nettype wire

// >>> tb/sctr_timer_sva.sv
// Port assertions for the channel timer.
`timescale 1ns/1ps
`default_nettype none
`include "sctr_map.svh"
module sctr_timer_sva (
  input wire logic                   clock,
  input wire logic                   rst,
  input wire logic [`SCTR_ADR_W-1:0] adr_i,
  input wire logic [31:0]            dat_i,
  input wire logic [31:0]            dat_o,
  input wire logic                   we_i,
  input wire logic [3:0]             sel_i,
  input wire logic                   cyc_i,
  input wire logic                   stb_i,
  input wire logic                   ack_o,
  input wire logic                   chanPin,
  input wire logic                   rtcClockSource,
  input wire logic                   extCrystalClock,
  input wire logic                   clockOutSelect,
  input wire logic                   chanOutput,
  input wire logic                   chanOutputComp,
  input wire logic                   overflowPulse
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_rd(a);
    ack_o && !we_i && adr_i == a;
  endsequence
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  property p_ack_ans; s_req |=> ack_o; endproperty
  property p_ack_req; ack_o |-> cyc_i && stb_i; endproperty
  property p_rst_quiet;
    disable iff (1'b0) rst |=> !ack_o && dat_o == 32'h0 && !chanOutput
      && !chanOutputComp && !overflowPulse;
  endproperty
  property p_hi_zero; ack_o && !we_i |-> dat_o[31:16] == 16'h0; endproperty
  property p_hold; ack_o ##1 !stb_i |-> $stable(dat_o); endproperty
  property p_unmap; s_rd(8'h40) |-> dat_o == 32'h0; endproperty
  property p_src; s_rd(`SCTR_OFF_SRC) |-> dat_o[15:2] == 14'h0; endproperty
  property p_cfg;
    s_rd(`SCTR_OFF_CFG) |-> (dat_o[15:0] & 16'hfffd) == 16'h0;
  endproperty
  property p_chctl;
    s_rd(`SCTR_OFF_CHCTL) |-> (dat_o[15:0] & 16'hfff4) == 16'h0;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  a_ack_ans: assert property (p_ack_ans) else $error("ack late");
  a_ack_req: assert property (p_ack_req) else $error("ack without request");
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs not quiet after reset");
  a_hi_zero: assert property (p_hi_zero) else $error("upper data not zero");
  a_hold: assert property (p_hold) else $error("read data changed");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_src: assert property (p_src)
    else $error("source select spare bits set");
  a_cfg: assert property (p_cfg)
    else $error("config spare bits set");
  a_chctl: assert property (p_chctl)
    else $error("channel control spare bits set");
endmodule
bind sctr_timer sctr_timer_sva sva_u (
  .clock(clock), .rst(rst), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
  .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .chanPin(chanPin), .rtcClockSource(rtcClockSource),
  .extCrystalClock(extCrystalClock), .clockOutSelect(clockOutSelect),
  .chanOutput(chanOutput), .chanOutputComp(chanOutputComp),
  .overflowPulse(overflowPulse)
);
`default_nettype wire

// >>> tb/sctr_far_model.sv
// Channel pin and the three free-running internal clock sources.
`timescale 1ns/1ps
`default_nettype none
module sctr_far_model (
  input  wire logic pinLevel,
  output wire logic chanPin,
  output var logic  rtcClockSource,
  output var logic  extCrystalClock,
  output var logic  clockOutSelect
);
  assign chanPin = pinLevel;
  initial begin
    rtcClockSource = 1'b0;
    forever #85 rtcClockSource = ~rtcClockSource;
  end
  initial begin
    extCrystalClock = 1'b0;
    forever #13 extCrystalClock = ~extCrystalClock;
  end
  initial begin
    clockOutSelect = 1'b0;
    forever #47 clockOutSelect = ~clockOutSelect;
  end
endmodule
`default_nettype wire

// >>> tb/test_single_channel_timer_counter_regs.sv
// Self-checking bench for the channel timer.
`timescale 1ns/1ps
`default_nettype none
`include "sctr_map.svh"
module test_single_channel_timer_counter_regs;
  logic        clock, rst, we, cyc, stb, ack, pinLevel, ovf;
  logic        chanPin, rtcSrc, xtalSrc, ckoSrc, chanOut, chanOutComp;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, got;
  logic [3:0]  sel;
  logic [15:0] v;
  logic [15:0] n [8];
  logic [7:0]  offs [8] = '{8'h00, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h34,
                            8'h50, 8'hfc};
  int          mismatches, compares, w, d1, d2, t1, m;
  int          now = 0;
  int          lastOvf = 0;
  sctr_timer dut_u (.clock(clock), .rst(rst), .adr_i(adr), .dat_i(wdat),
    .dat_o(rdat), .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb),
    .ack_o(ack), .chanPin(chanPin), .rtcClockSource(rtcSrc),
    .extCrystalClock(xtalSrc), .clockOutSelect(ckoSrc),
    .chanOutput(chanOut), .chanOutputComp(chanOutComp),
    .overflowPulse(ovf));
  sctr_far_model far_u (.pinLevel(pinLevel), .chanPin(chanPin),
    .rtcClockSource(rtcSrc), .extCrystalClock(xtalSrc),
    .clockOutSelect(ckoSrc));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) now <= now + 1;
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic isWr, input logic [7:0] a,
                     input logic [15:0] d);
    int k;
    k = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= isWr;
    adr <= a;
    wdat <= {16'h0, d};
    do begin
      @(posedge clock);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (k >= 20) mismatches++;
    got = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 16'h0);
    chk(got, e);
  endtask
  task automatic wait_ovf(output int gap);
    int k;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (ovf !== 1'b1 && k < 500);
    if (k >= 500) mismatches++;
    gap = now - lastOvf;
    lastOvf = now;
  endtask
  task automatic edge_cap(input logic l, input logic [15:0] c,
                          input logic [15:0] e);
    wr(`SCTR_OFF_CNT, c);
    @(posedge clock);
    pinLevel <= l;
    repeat (6) @(posedge clock);
    rd_chk(`SCTR_OFF_CHVAL, {16'h0, e});
  endtask
  function automatic logic [15:0] msk(input logic [7:0] a);
    return a == 8'h50 ? 16'h0003 : (a == 8'hfc ? 16'h0002 : 16'hffff);
  endfunction
  function automatic logic [1:0] outs(input int k, input logic r);
    return k[0] ? {r ^ k[1], ~r ^ k[2]} : {k[1], k[2]};
  endfunction
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    give_verdict();
  end
  initial begin
    {cyc, stb, we, pinLevel, rst} = 5'h01;
    adr = 8'h00;
    wdat = 32'h0;
    sel = 4'hf;
    mismatches = 0;
    compares = 0;
    void'($urandom(82170));
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    foreach (offs[i]) rd_chk(offs[i], 32'h0);
    for (int i = 2; i < 8; i++) begin
      v = $urandom;
      wr(offs[i], v);
      rd_chk(offs[i], {16'h0, v & msk(offs[i])});
    end
    wr(8'h40, v);
    rd_chk(8'h40, 32'h0);
    wr(`SCTR_OFF_CHVAL, 16'd100);
    for (m = 0; m < 16; m++) begin
      v = m[3] ? 16'd100 + $urandom_range(3) : 16'd99 - $urandom_range(3);
      wr(`SCTR_OFF_CNT, v);
      wr(`SCTR_OFF_CHCTL, {12'h0, m[2], 1'b0, m[1], m[0]});
      repeat (2) @(posedge clock);
      got = {30'h0, chanOut, chanOutComp};
      chk(got, {30'h0, outs(m, v < 100)});
    end
    for (int p = 1; p < 4; p++) begin
      wr(`SCTR_OFF_CTRL, 16'h0);
      wr(`SCTR_OFF_CHCTL, 16'h0);
      wr(`SCTR_OFF_CTRL, {10'h0, p[1:0], 4'h0});
      wr(`SCTR_OFF_CHCTL, 16'h000a);
      rd_chk(`SCTR_OFF_CHCTL, p == 1 ? 32'ha : 32'h0);
    end
    wr(`SCTR_OFF_CTRL, 16'h0004);
    wr(`SCTR_OFF_CHCTL, 16'h0001);
    wr(`SCTR_OFF_EVGEN, 16'h0001);
    wr(`SCTR_OFF_CNT, 16'd50);
    wr(`SCTR_OFF_CHVAL, 16'd20);
    repeat (2) @(posedge clock);
    chk({31'h0, chanOut}, 32'h1);
    wr(`SCTR_OFF_EVGEN, 16'h0001);
    wr(`SCTR_OFF_CNT, 16'd50);
    repeat (2) @(posedge clock);
    chk({31'h0, chanOut}, 32'h0);
    w = $urandom_range(6, 2);
    d1 = $urandom_range(4, 1);
    d2 = d1 + 1 + $urandom_range(2);
    wr(`SCTR_OFF_WRAP, w[15:0]);
    wr(`SCTR_OFF_DIV, d1[15:0]);
    wr(`SCTR_OFF_EVGEN, 16'h0001);
    wr(`SCTR_OFF_CTRL, 16'h0001);
    wait_ovf(t1);
    wr(`SCTR_OFF_DIV, d2[15:0]);
    wait_ovf(t1);
    chk(t1, (d1 + 1) * (w + 1));
    wait_ovf(t1);
    chk(t1, (d2 + 1) * (w + 1));
    wr(`SCTR_OFF_CHVAL, w[15:0]);
    wr(`SCTR_OFF_FLAG, 16'h0);
    wait_ovf(t1);
    rd_chk(`SCTR_OFF_FLAG, 32'h3);
    foreach (n[i]) n[i] = $urandom;
    wr(`SCTR_OFF_CTRL, 16'h0002);
    wr(`SCTR_OFF_SRC, 16'h0);
    wr(`SCTR_OFF_CHCTL, 16'h0001);
    wr(`SCTR_OFF_FLAG, 16'h0);
    edge_cap(1'b1, n[0], n[0]);
    rd_chk(`SCTR_OFF_FLAG, 32'h2);
    wr(`SCTR_OFF_CHVAL, ~n[0]);
    edge_cap(1'b0, n[1], n[0]);
    edge_cap(1'b1, n[2], n[2]);
    rd_chk(`SCTR_OFF_FLAG, 32'h202);
    // Input mode never uses the pair comp 1 with main 0.
    wr(`SCTR_OFF_CHCTL, 16'h0003);
    edge_cap(1'b0, n[3], n[3]);
    edge_cap(1'b1, n[4], n[3]);
    wr(`SCTR_OFF_CHCTL, 16'h000b);
    edge_cap(1'b0, n[5], n[5]);
    edge_cap(1'b1, n[6], n[6]);
    wr(`SCTR_OFF_CHCTL, 16'h0000);
    edge_cap(1'b0, n[7], n[6]);
    wr(`SCTR_OFF_CHCTL, 16'h000b);
    for (int s = 1; s < 5; s++) begin
      v = $urandom;
      wr(`SCTR_OFF_SRC, {14'h0, s[1:0]});
      repeat (5) @(posedge clock);
      wr(`SCTR_OFF_CNT, s == 4 ? ~n[6] : v);
      repeat (300) @(posedge clock);
      rd_chk(`SCTR_OFF_CHVAL, {16'h0, s == 4 ? n[6] : v});
      n[6] = v;
    end
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    foreach (offs[i]) rd_chk(offs[i], 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
